// ==== p4gp_defines.svh ====
// Register offsets, reset values and field positions of the port-four pin mux
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Data read returns stored value for lower bits whose direction bit is one.
// - Data read returns pin level for bits whose direction bit is zero.
// - Data register resets to 0xf8: upper five ones, outputs cleared.
// - Direction bit one makes the lower pin an output, zero an input.
// - Direction register resets to 0xf8, lower pins start as inputs.
// - Direction register is write-only and always reads all ones.
// - Data and direction drive a pad only while the pin is in general use.
// - Bit two drives serial transmit when pin enable and transmit enable set.
// - Bit one is serial receive input whenever receive enable is set.
// - Bit zero: clock input, clock output, or general use per clock bits.
// - Interrupt pin high in reset, held in low power; shared pins float in standby, hold their state in hold.
// - Bit three connects only to the on-chip decoder, never a pin.
// ----------------------------------------------------------------------------
`ifndef P4GP_DEFINES_SVH
`define P4GP_DEFINES_SVH
`define P4GP_DATA_OFS 12'h000
`define P4GP_DIR_OFS 12'h004
`define P4GP_SERCFG_OFS 12'h008
`define P4GP_MODE_OFS 12'h00c
`define P4GP_DATA_RST 8'hf8
`define P4GP_DIR_RST 8'hf8
`define P4GP_UPPER_ONES 8'hf8
`define P4GP_SER_PINEN 0
`define P4GP_SER_TE 1
`define P4GP_SER_RE 2
`define P4GP_SER_CKHI 3
`define P4GP_SER_CKLO 4
`define P4GP_SER_COM 5
`define P4GP_MODE_IRQSEL 0
`endif

// ==== p4gp_pkg.sv ====
// Types shared by the port-four pin mux
package p4gp_pkg;
  typedef struct packed {
    logic tx_data; // Serial transmit data from channel two
    logic sck_out; // Serial clock driven by channel two
  } p4gp_ser_out_t;
  typedef struct packed {
    logic rx_data; // Receive level toward channel two
    logic sck_in;  // Clock level toward channel two
  } p4gp_ser_in_t;
  typedef enum logic [1:0] {
    P4GP_ACTIVE = 2'b00,
    P4GP_HOLD = 2'b01,
    P4GP_STANDBY = 2'b10
  } p4gp_pmode_t;
endpackage

// ==== p4gp_port.sv ====
// Port-four pin mux with data and direction registers behind an APB slave
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "p4gp_defines.svh"
module p4gp_port (
  input wire logic SYS_CLK, // 125 MHz system clock
  input wire logic RESET, // Asynchronous reset, active high
  input wire logic PSEL, // APB select
  input wire logic PENABLE, // APB access phase
  input wire logic PWRITE, // APB direction
  input wire logic [11:0] PADDR, // APB byte address
  input wire logic [31:0] PWDATA, // APB write data
  output logic [31:0] PRDATA, // APB read data
  output logic PREADY, // APB ready
  output logic PSLVERR, // APB error on unmapped address
  input wire logic [2:0] PIN_IN, // Pad input levels, bits 2..0
  output logic [2:0] PIN_OUT, // Pad output levels
  output logic [2:0] PIN_OE, // Pad output enables, high drives
  input wire p4gp_pkg::p4gp_pmode_t PWR_MODE, // Active, hold or standby
  input wire logic DEC_IRQ_LINE, // Internal line from the pager decoder
  output logic DEC_IRQ_REQ, // Interrupt request, active low
  output logic DEC_GP_IN, // Bit three as general input level
  input wire p4gp_pkg::p4gp_ser_out_t SER_OUT, // From serial channel two
  output p4gp_pkg::p4gp_ser_in_t SER_IN // To serial channel two
);
  import p4gp_pkg::*;

  // ----------------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------------
  logic [2:0] pin_s1, pin_s2;
  logic irq_s1, irq_s2;
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      pin_s1 <= 3'h7;
      pin_s2 <= 3'h7;
      irq_s1 <= 1'b1;
      irq_s2 <= 1'b1;
    end else begin
      pin_s1 <= PIN_IN;
      pin_s2 <= pin_s1;
      irq_s1 <= DEC_IRQ_LINE;
      irq_s2 <= irq_s1;
    end
  end

  // ----------------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------------
  logic [7:0] data_reg, dir_reg;
  logic [5:0] ser_cfg;
  logic mode_reg;
  logic [7:0] next_data_reg, next_dir_reg;
  logic [5:0] next_ser_cfg;
  logic next_mode_reg;
  logic wr_acc, addr_ok;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  always_comb begin
    addr_ok = (PADDR == `P4GP_DATA_OFS) || (PADDR == `P4GP_DIR_OFS) ||
              (PADDR == `P4GP_SERCFG_OFS) || (PADDR == `P4GP_MODE_OFS);
  end
  always_comb begin
    next_data_reg = data_reg;
    next_dir_reg = dir_reg;
    next_ser_cfg = ser_cfg;
    next_mode_reg = mode_reg;
    if (wr_acc) begin
      unique case (PADDR)
        `P4GP_DATA_OFS: next_data_reg = `P4GP_UPPER_ONES | {5'h00, PWDATA[2:0]};
        `P4GP_DIR_OFS: next_dir_reg = `P4GP_UPPER_ONES | {5'h00, PWDATA[2:0]};
        `P4GP_SERCFG_OFS: next_ser_cfg = PWDATA[5:0];
        `P4GP_MODE_OFS: next_mode_reg = PWDATA[`P4GP_MODE_IRQSEL];
        default: next_data_reg = data_reg;
      endcase
    end
  end
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      data_reg <= `P4GP_DATA_RST;
      dir_reg <= `P4GP_DIR_RST;
      ser_cfg <= 6'h00;
      mode_reg <= 1'b0;
    end else begin
      data_reg <= next_data_reg;
      dir_reg <= next_dir_reg;
      ser_cfg <= next_ser_cfg;
      mode_reg <= next_mode_reg;
    end
  end

  // ----------------------------------------------------------------------------
  // Pin function selection
  // ----------------------------------------------------------------------------
  logic tx_sel, rx_sel, ck_in_sel, ck_out_sel;
  logic [2:0] gp_use, drv, lvl;
  assign tx_sel = ser_cfg[`P4GP_SER_PINEN] && ser_cfg[`P4GP_SER_TE];
  assign rx_sel = ser_cfg[`P4GP_SER_RE];
  assign ck_in_sel = ser_cfg[`P4GP_SER_CKHI];
  assign ck_out_sel = !ser_cfg[`P4GP_SER_CKHI] &&
                      (ser_cfg[`P4GP_SER_CKLO] || ser_cfg[`P4GP_SER_COM]);
  assign gp_use = {!tx_sel, !rx_sel, !(ck_in_sel || ck_out_sel)};
  always_comb begin
    drv[2] = tx_sel ? 1'b1 : dir_reg[2];
    drv[1] = rx_sel ? 1'b0 : dir_reg[1];
    drv[0] = ck_in_sel ? 1'b0 : (ck_out_sel ? 1'b1 : dir_reg[0]);
    lvl[2] = tx_sel ? SER_OUT.tx_data : data_reg[2];
    lvl[1] = data_reg[1];
    lvl[0] = ck_out_sel ? SER_OUT.sck_out : data_reg[0];
  end

  // Hold keeps the last pad state; standby floats the shared pins
  logic [2:0] oe_q, out_q;
  logic [2:0] next_oe_q, next_out_q;
  logic irq_q, next_irq_q;
  always_comb begin
    next_oe_q = oe_q;
    next_out_q = out_q;
    next_irq_q = irq_q;
    unique case (PWR_MODE)
      P4GP_ACTIVE: begin
        next_oe_q = drv;
        next_out_q = lvl;
        next_irq_q = irq_s2;
      end
      P4GP_HOLD: next_irq_q = irq_q;
      P4GP_STANDBY: next_oe_q = 3'h0;
      default: next_oe_q = 3'h0;
    endcase
  end
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      oe_q <= 3'h0;
      out_q <= 3'h0;
      irq_q <= 1'b1;
    end else begin
      oe_q <= next_oe_q;
      out_q <= next_out_q;
      irq_q <= next_irq_q;
    end
  end
  assign PIN_OE = oe_q;
  assign PIN_OUT = out_q;
  // Bit three never reaches a pad, only the decoder line
  assign DEC_IRQ_REQ = mode_reg ? irq_q : 1'b1;
  assign DEC_GP_IN = irq_q;
  assign SER_IN.rx_data = pin_s2[1];
  assign SER_IN.sck_in = pin_s2[0];

  // ----------------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------------
  logic [7:0] data_view;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_rd
      // Direction one returns the latch, zero the pad
      assign data_view[gi] = dir_reg[gi] ? data_reg[gi] : pin_s2[gi];
    end
  endgenerate
  assign data_view[7:3] = {4'hf, (mode_reg ? 1'b1 : irq_q)};
  always_comb begin
    PRDATA = 32'h0000_0000;
    if (PSEL && !PWRITE) begin
      unique case (PADDR)
        `P4GP_DATA_OFS: PRDATA = {24'h000000, data_view};
        `P4GP_DIR_OFS: PRDATA = {24'h000000, 8'hff};
        `P4GP_SERCFG_OFS: PRDATA = {26'h0000000, ser_cfg};
        `P4GP_MODE_OFS: PRDATA = {31'h00000000, mode_reg};
        default: PRDATA = 32'h0000_0000;
      endcase
    end
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_DIR_READ_ONES: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DIR_OFS) |-> PRDATA[7:0] == 8'hff)
    else $error("direction read not all ones");
  AST_UPPER_ONES: assert property (@(posedge SYS_CLK) disable iff (RESET)
    data_reg[7:3] == 5'h1f && dir_reg[7:3] == 5'h1f)
    else $error("upper bits lost their ones");
  AST_READ_LATCH: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && dir_reg[2]) |-> PRDATA[2] == data_reg[2])
    else $error("output bit read did not return latch");
  AST_READ_PIN: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && !dir_reg[0]) |-> PRDATA[0] == pin_s2[0])
    else $error("input bit read did not return pin");
  AST_TX_DRIVE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (tx_sel && PWR_MODE == P4GP_ACTIVE) |=> PIN_OE[2])
    else $error("transmit pin not driven");
  AST_RX_INPUT: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (rx_sel && PWR_MODE == P4GP_ACTIVE) |=> !PIN_OE[1])
    else $error("receive pin driven");
  AST_CK_INPUT: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (ck_in_sel && PWR_MODE == P4GP_ACTIVE) |=> !PIN_OE[0])
    else $error("clock input pin driven");
  AST_STANDBY_FLOAT: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PWR_MODE == P4GP_STANDBY) |=> PIN_OE == 3'h0)
    else $error("shared pins driven in standby");
  AST_HOLD_IRQ: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PWR_MODE == P4GP_HOLD) |=> $stable(irq_q))
    else $error("interrupt level moved in hold");
  AST_DIR_WRITE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_acc && PADDR == `P4GP_DIR_OFS) |=> dir_reg[2:0] == $past(PWDATA[2:0]))
    else $error("direction write not stored");

  // ----------------------------------------------------------------------------
  // Read path checks
  // ----------------------------------------------------------------------------
  AST_READ_LATCH_MID: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && dir_reg[1]) |-> PRDATA[1] == data_reg[1])
    else $error("middle output bit read did not return latch");
  AST_READ_LATCH_LOW: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && dir_reg[0]) |-> PRDATA[0] == data_reg[0])
    else $error("low output bit read did not return latch");
  AST_READ_PIN_MID: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && !dir_reg[1]) |-> PRDATA[1] == pin_s2[1])
    else $error("middle input bit read did not return pin");
  AST_READ_PIN_HIGH: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && !dir_reg[2]) |-> PRDATA[2] == pin_s2[2])
    else $error("high input bit read did not return pin");
  AST_READ_UPPER: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS) |-> PRDATA[7:4] == 4'hf)
    else $error("upper data bits did not read as ones");
  AST_READ_BIT3_GP: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && !mode_reg) |-> PRDATA[3] == irq_q)
    else $error("bit three read did not return line level");
  AST_READ_BIT3_IRQ: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PSEL && !PWRITE && PADDR == `P4GP_DATA_OFS && mode_reg) |-> PRDATA[3])
    else $error("bit three read not one under interrupt use");
  AST_READ_IDLE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !(PSEL && !PWRITE) |-> PRDATA == 32'h0000_0000)
    else $error("read data not zero outside a read");
  AST_READY: assert property (@(posedge SYS_CLK) disable iff (RESET)
    PREADY)
    else $error("ready dropped");

  // ----------------------------------------------------------------------------
  // Register write checks
  // ----------------------------------------------------------------------------
  // Writes land at the access edge, so the stored value shows one edge later
  AST_DATA_WRITE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_acc && PADDR == `P4GP_DATA_OFS) |=> data_reg[2:0] == $past(PWDATA[2:0]))
    else $error("data write not stored");
  AST_CFG_WRITE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_acc && PADDR == `P4GP_SERCFG_OFS) |=> ser_cfg == $past(PWDATA[5:0]))
    else $error("serial configuration write not stored");
  AST_MODE_WRITE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_acc && PADDR == `P4GP_MODE_OFS) |=> mode_reg == $past(PWDATA[0]))
    else $error("mode write not stored");
  AST_UNMAPPED_WRITE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (wr_acc && !addr_ok) |=> $stable(data_reg) && $stable(dir_reg))
    else $error("unmapped write changed a port register");

  // ----------------------------------------------------------------------------
  // Pad checks
  // ----------------------------------------------------------------------------
  AST_GP_DRIVE: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!tx_sel && PWR_MODE == P4GP_ACTIVE) |=> PIN_OE[2] == $past(dir_reg[2]))
    else $error("general bit two enable not from direction");
  AST_GP_LEVEL: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!tx_sel && PWR_MODE == P4GP_ACTIVE) |=> PIN_OUT[2] == $past(data_reg[2]))
    else $error("general bit two level not from data");
  AST_TX_LEVEL: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (tx_sel && PWR_MODE == P4GP_ACTIVE) |=> PIN_OUT[2] == $past(SER_OUT.tx_data))
    else $error("transmit pin level not from channel");
  AST_RX_GP: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!rx_sel && PWR_MODE == P4GP_ACTIVE) |=> PIN_OE[1] == $past(dir_reg[1]))
    else $error("general bit one enable not from direction");
  AST_CK_OUTPUT: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (ck_out_sel && PWR_MODE == P4GP_ACTIVE) |=> PIN_OE[0] && PIN_OUT[0] == $past(SER_OUT.sck_out))
    else $error("clock output pin not driven from channel");
  AST_CK_GP: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (!ck_in_sel && !ck_out_sel && PWR_MODE == P4GP_ACTIVE) |=> PIN_OE[0] == $past(dir_reg[0]))
    else $error("general bit zero enable not from direction");
  AST_RX_PASS: assert property (@(posedge SYS_CLK) disable iff (RESET)
    SER_IN.rx_data == pin_s2[1])
    else $error("receive level not passed to channel");

  // ----------------------------------------------------------------------------
  // Low-power and interrupt checks
  // ----------------------------------------------------------------------------
  AST_HOLD_PADS: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PWR_MODE == P4GP_HOLD) |=> $stable(PIN_OE) && $stable(PIN_OUT))
    else $error("pads moved in hold");
  AST_STANDBY_IRQ: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PWR_MODE == P4GP_STANDBY) |=> $stable(irq_q))
    else $error("interrupt level moved in standby");
  AST_ACTIVE_IRQ: assert property (@(posedge SYS_CLK) disable iff (RESET)
    (PWR_MODE == P4GP_ACTIVE) |=> irq_q == $past(irq_s2))
    else $error("interrupt level not following the line");
  AST_IRQ_MASKED: assert property (@(posedge SYS_CLK) disable iff (RESET)
    !mode_reg |-> DEC_IRQ_REQ)
    else $error("request raised while bit three is a general input");
  AST_IRQ_FOLLOW: assert property (@(posedge SYS_CLK) disable iff (RESET)
    mode_reg |-> DEC_IRQ_REQ == DEC_GP_IN)
    else $error("request not following the line level");

  COV_HOLD: cover property (@(posedge SYS_CLK) disable iff (RESET) PWR_MODE == P4GP_HOLD && !irq_q);
  COV_TX: cover property (@(posedge SYS_CLK) disable iff (RESET) tx_sel && PIN_OE[2]);
  COV_CKOUT: cover property (@(posedge SYS_CLK) disable iff (RESET) ck_out_sel && PIN_OE[0]);
  COV_GPOUT: cover property (@(posedge SYS_CLK) disable iff (RESET) gp_use[1] && PIN_OE[1]);
  COV_IRQ: cover property (@(posedge SYS_CLK) disable iff (RESET) mode_reg && !DEC_IRQ_REQ);
endmodule

// ==== p4gp_far.sv ====
// Pad and outside-world model facing the port-four pin mux
`timescale 1ns/10ps
module p4gp_far (
  input wire logic [2:0] pin_out, // Levels the port drives
  input wire logic [2:0] pin_oe, // Port enables, high drives
  input wire logic [2:0] ext_drv, // Levels the outside world drives
  output logic [2:0] pin_in // Resolved pad levels
);
  // The outside drives every pad the port releases, so no pad floats
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_drv);
endmodule

// ==== testbench.sv ====
// Self-checking bench for the port-four pin mux
`timescale 1ns/10ps
`include "p4gp_defines.svh"
module testbench;
  import p4gp_pkg::*;
  typedef struct packed {
    logic [5:0] cfg;
    logic [2:0] dir;
    logic [2:0] dat;
    logic [2:0] oe;
    logic [2:0] out;
  } p4gp_row_t;
  logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, er;
  logic dec_line, dec_req, dec_gp;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pin_in, pin_out, pin_oe, ext_drv;
  p4gp_pmode_t pwr_mode;
  p4gp_ser_out_t ser_out;
  p4gp_ser_in_t ser_in;
  int fails, tests_run;
  p4gp_row_t rows [9];

  p4gp_port dut (.SYS_CLK(sys_clk), .RESET(reset), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
    .PWR_MODE(pwr_mode), .DEC_IRQ_LINE(dec_line), .DEC_IRQ_REQ(dec_req),
    .DEC_GP_IN(dec_gp), .SER_OUT(ser_out), .SER_IN(ser_in));
  p4gp_far far (.pin_out(pin_out), .pin_oe(pin_oe), .ext_drv(ext_drv), .pin_in(pin_in));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: %s", $time, msg);
      fails++;
    end
  endtask

  // Master holds the request until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 100) fails++;
  endtask

  task automatic rd_data(input logic [31:0] exp, input string msg);
    repeat (3) @(posedge sys_clk);
    apb(1'b0, `P4GP_DATA_OFS, 32'h0);
    chk(rd, exp, msg);
  endtask

  task automatic end_of_test();
    if (fails == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pwr_mode = P4GP_ACTIVE;
    ser_out = 2'b11;
    ext_drv = 3'b000;
    dec_line = 1'b1;
    rows = '{'{6'h00, 3'h7, 3'h5, 3'h7, 3'h5}, '{6'h00, 3'h0, 3'h7, 3'h0, 3'h0},
      '{6'h03, 3'h7, 3'h0, 3'h7, 3'h4}, '{6'h02, 3'h0, 3'h0, 3'h0, 3'h0},
      '{6'h04, 3'h7, 3'h0, 3'h5, 3'h0}, '{6'h08, 3'h7, 3'h0, 3'h6, 3'h0},
      '{6'h10, 3'h0, 3'h0, 3'h1, 3'h1}, '{6'h20, 3'h0, 3'h0, 3'h1, 3'h1},
      '{6'h18, 3'h0, 3'h0, 3'h0, 3'h0}};
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    rd_data(32'hf8, "data after reset");
    chk(32'(pin_oe), 32'h0, "pads start as inputs");
    apb(1'b0, `P4GP_DIR_OFS, 32'h0);
    chk(rd, 32'hff, "direction read");
    apb(1'b1, `P4GP_DATA_OFS, 32'hff);
    rd_data(32'hf8, "upper bits and inputs");
    apb(1'b1, `P4GP_DIR_OFS, 32'hfd);
    rd_data(32'hfd, "mixed direction read");
    foreach (rows[i]) begin
      apb(1'b1, `P4GP_SERCFG_OFS, 32'(rows[i].cfg));
      apb(1'b1, `P4GP_DIR_OFS, 32'(rows[i].dir));
      apb(1'b1, `P4GP_DATA_OFS, 32'(rows[i].dat));
      repeat (3) @(posedge sys_clk);
      chk(32'(pin_oe), 32'(rows[i].oe), "pad enable");
      chk(32'(pin_out & rows[i].oe), 32'(rows[i].out), "pad level");
    end
    ext_drv <= 3'b010;
    apb(1'b1, `P4GP_SERCFG_OFS, 32'h04);
    apb(1'b1, `P4GP_DIR_OFS, 32'h07);
    rd_data(32'hf8, "stored value under receive");
    chk(32'(ser_in.rx_data), 32'h1, "receive level");
    apb(1'b1, `P4GP_SERCFG_OFS, 32'h0);
    apb(1'b1, `P4GP_DIR_OFS, 32'h0);
    rd_data(32'hfa, "pin level read");
    dec_line <= 1'b0;
    rd_data(32'hf2, "bit three as input");
    chk(32'(dec_gp), 32'h0, "general input level");
    apb(1'b1, `P4GP_MODE_OFS, 32'h1);
    rd_data(32'hfa, "bit three under interrupt");
    chk(32'(dec_req), 32'h0, "interrupt request");
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0, "unmapped read data");
    chk(32'(er), 32'h1, "unmapped error");
    apb(1'b1, `P4GP_DIR_OFS, 32'h07);
    pwr_mode <= P4GP_STANDBY;
    repeat (3) @(posedge sys_clk);
    chk(32'(pin_oe), 32'h0, "standby floats pads");
    pwr_mode <= P4GP_ACTIVE;
    repeat (3) @(posedge sys_clk);
    chk(32'(pin_oe), 32'h7, "active drives again");
    pwr_mode <= P4GP_HOLD;
    dec_line <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(32'(dec_gp), 32'h0, "hold keeps interrupt level");
    chk(32'(pin_oe), 32'h7, "hold keeps pads");
    pwr_mode <= P4GP_ACTIVE;
    repeat (4) @(posedge sys_clk);
    chk(32'(dec_gp), 32'h1, "level follows again");
    ser_out <= 2'b00;
    apb(1'b1, `P4GP_DATA_OFS, 32'h07);
    apb(1'b1, `P4GP_SERCFG_OFS, 32'h13);
    repeat (3) @(posedge sys_clk);
    chk(32'(pin_out), 32'h2, "serial levels follow channel");
    reset <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk(32'(pin_oe), 32'h0, "pads float in reset");
    chk(32'(dec_req), 32'h1, "request high in reset");
    reset <= 1'b0;
    dec_line <= 1'b1;
    rd_data(32'hfa, "data after second reset");
    end_of_test();
  end
endmodule
